//--- dv/pmes_host_model.sv
// host-side model of the register port master
`timescale 1ns/1ns
`default_nettype none
`include "pmes_defs.svh"

module pmes_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] regAddr,
	output logic regWr,
	output logic regRd,
	output logic [7:0] regWdata,
	input wire logic [7:0] regRdata
);
	// idle bus, strobes low
	initial begin
		regAddr = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		regWdata = 8'h00;
	end

	// one-cycle write; address and data inverted afterwards so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWdata = d;
		regWr = 1'b1;
		@(negedge clk);
		regWr = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask

	// read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regRd = 1'b1;
		@(negedge clk);
		regRd = 1'b0;
		regAddr = ~a;
		d = regRdata;
	endtask

	// sink fields are only ever written both set or both clear
	task automatic wrPath(input logic off);
		wr(`PMES_REG_PATHCTL, {off, off, 6'h00});
	endtask

	// continuous event: mask it, poll until its flag clears, then unmask
	task automatic muteWait(input logic [3:0] ev, output logic [7:0] last);
		wr(`PMES_REG_INT, {ev, 4'h0});
		for (int i = 0; i < 30; i++) begin
			rd(`PMES_REG_INT, last);
			if ((last[3:0] & ev) == 4'h0) break;
			repeat (200) @(negedge clk);
		end
		wr(`PMES_REG_INT, 8'h00);
	endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the supervisory block
`timescale 1ns/1ns
`default_nettype none
`include "pmes_defs.svh"

module tb_top import pmes_pkg::*; ();
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hardClearPinN = 1'b1;
	logic buttonInN = 1'b1;
	logic chargerOn = 1'b0;
	logic [`PMES_CMP_W-1:0] cmpRaw = 15'h0600;
	wire logic [7:0] regAddr, regWdata, regRdata;
	wire logic regWr, regRd;
	logic eventReqPinOut, eventReqPinOe, railsOn, seqStart;
	logic acBleedOn, usbBleedOn, shortTestSrc, detSrc;
	pmes_path_t pathSel;
	pmes_chg_t chgPhase;
	int miscompares = 0;
	int checksDone = 0;
	// presence-check period used at the instance; the off span follows from it
	localparam int DetPeriod = 2000;
	// open-drain request line with pull-up
	wire logic evPinN = eventReqPinOe ? eventReqPinOut : 1'b1;

	always #4 clk = ~clk;

	// ----------------------------------------
	// instances
	// ----------------------------------------
	pmes_supervisor #(.HOLD_CYC(200), .DET_PERIOD_CYC(DetPeriod)) uut (.clk(clk), .srst(srst),
		.hardClearPinN(hardClearPinN), .buttonInN(buttonInN), .chargerOn(chargerOn),
		.eventReqPinOut(eventReqPinOut), .eventReqPinOe(eventReqPinOe), .cmpRaw(cmpRaw),
		.regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
		.regRdata(regRdata), .railsOn(railsOn), .seqStart(seqStart), .pathSel(pathSel),
		.acBleedOn(acBleedOn), .usbBleedOn(usbBleedOn), .chgPhase(chgPhase),
		.shortTestSrc(shortTestSrc), .detSrc(detSrc));
	pmes_host_model uHost (.clk(clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
		.regWdata(regWdata), .regRdata(regRdata));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// apply a comparator word, let synchronisers settle, check path and sinks
	task automatic step(input logic [14:0] c, input logic [3:0] e, input logic bl);
		@(negedge clk);
		cmpRaw = c;
		cyc(8);
		chk("path sinks", {4'h0, e}, {4'h0, pathSel, bl ? {acBleedOn, usbBleedOn} : 2'b00});
	endtask

	task automatic stopTest();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fault();
		logic [7:0] d;
		int n;
		uHost.rd(`PMES_REG_INT, d);
		@(negedge clk);
		cmpRaw[`PMES_C_FAULT] = 1'b1;
		cyc(6);
		chk("pin on fault", 8'h00, 8'(evPinN));
		uHost.rd(`PMES_REG_INT, d);
		chk("fault flag", 8'h08, d);
		cyc(1);
		chk("pin released", 8'h01, 8'(evPinN));
		for (n = 0; n < 4000 && evPinN !== 1'b0; n++) cyc(1);
		chk("redrive in 32us", 8'h01, 8'(n < 4000));
		fork
			uHost.muteWait(4'h8, d);
			begin
				cyc(600);
				chk("masked pin", 8'h01, 8'(evPinN));
				cmpRaw[`PMES_C_FAULT] = 1'b0;
			end
		join
		chk("flag resolved", 8'h80, d);
		$display("test fault done");
	endtask

	task automatic t_button();
		logic [7:0] d;
		uHost.rd(`PMES_REG_INT, d);
		for (int v = 0; v < 2; v++) begin
			@(negedge clk);
			buttonInN = v[0];
			cyc(8);
			chk("button pin", 8'h00, 8'(evPinN));
			uHost.rd(`PMES_REG_INT, d);
			chk("button flag", 8'h01, d);
		end
		$display("test button done");
	endtask

	task automatic t_path();
		logic [14:0] cw [5] = '{15'h0660, 15'h0640, 15'h0600, 15'h0780, 15'h07e0};
		logic [3:0] ex [5] = '{4'b0101, 4'b0101, 4'b0000, 4'b1010, 4'b0100};
		logic [7:0] d;
		for (int i = 0; i < 5; i++) step(cw[i], ex[i], 1'b1);
		step(15'h0780, 4'b1010, 1'b1);
		uHost.wrPath(1'b1);
		uHost.rd(`PMES_REG_PATHCTL, d);
		chk("path ctl readback", 8'hc0, d);
		chk("sinks forced off", 8'h00, {6'h00, acBleedOn, usbBleedOn});
		uHost.wrPath(1'b0);
		$display("test path done");
	endtask

	task automatic t_lowbat();
		logic [14:0] cw [8] = '{15'h0008, 15'h000d, 15'h000c, 15'h001e, 15'h001a,
			15'h021e, 15'h021a, 15'h0212};
		logic [3:0] ex [8] = '{4'h0, 4'h4, 4'h4, 4'h4, 4'h8, 4'h4, 4'h4, 4'h8};
		for (int i = 0; i < 8; i++) step(cw[i], ex[i], 1'b0);
		step(15'h0600, 4'h0, 1'b0);
		$display("test low battery done");
	endtask

	task automatic t_charger();
		int n;
		step(15'h0660, 4'b0101, 1'b1);
		chargerOn = 1'b1;
		cyc(8);
		chk("short test", 8'(CH_SHORT), 8'(chgPhase));
		chk("short source", 8'h01, 8'(shortTestSrc));
		for (int b = 0; b < 3; b++) begin
			cmpRaw[`PMES_C_BATSC + b] = 1'b1;
			cyc(8);
			chk("charge phase", 8'(b + 2), 8'(chgPhase));
		end
		for (n = 0; n < 2100 && detSrc !== 1'b0; n++) cyc(1);
		chk("presence source on", 8'h01, 8'(n > 0 && n < 2100));
		for (n = 0; n < 2100 && detSrc !== 1'b1; n++) cyc(1);
		// source must come back after the period less the pulse, not stay off
		chk("presence source off", 8'h01,
			8'(n >= DetPeriod - `PMES_DET_ON_CYC - 1 && n <= DetPeriod - `PMES_DET_ON_CYC + 1));
		chargerOn = 1'b0;
		cyc(8);
		chk("charger idle", 8'(CH_IDLE), 8'(chgPhase));
		$display("test charger done");
	endtask

	task automatic t_hard();
		logic [7:0] d;
		int lc [2] = '{2, 300};
		int n;
		int lim;
		for (int k = 0; k < 2; k++) begin
			uHost.wrPath(1'b1);
			lim = lc[k] > 200 ? lc[k] : 200;
			hardClearPinN = 1'b0;
			for (n = 0; n < 2000 && seqStart !== 1'b1; n++) begin
				cyc(1);
				if (n == lc[k]) hardClearPinN = 1'b1;
				if (n == 1) chk("rails off", 8'h00, 8'(railsOn));
			end
			chk("hold span", 8'h01, 8'(n >= lim && n <= lim + 8));
			cyc(1);
			chk("rails back", 8'h01, 8'(railsOn));
			uHost.rd(`PMES_REG_PATHCTL, d);
			chk("path ctl default", `PMES_PATHCTL_RST, d);
		end
		$display("test hard clear done");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		cyc(2);
		srst = 1'b0;
		uHost.rd(`PMES_REG_PATHCTL, d);
		chk("path ctl reset", `PMES_PATHCTL_RST, d);
		t_fault();
		t_button();
		t_path();
		t_lowbat();
		t_charger();
		t_hard();
		stopTest();
	end

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		stopTest();
	end
endmodule
`default_nettype wire

//--- inc/pmes_defs.svh
// constants for the supervisory logic: offsets, fields, timing
// Functional notes
// [RULE1] hard clear low: rails off, registers default
// [RULE2] rails stay off at least one second
// [RULE3] clear released: active state, power-up sequence
// [RULE4] event sets flag, request pin pulled low
// [RULE5] interrupt register read clears flags, releases pin
// [RULE6] persisting failure re-asserts pin within 32 us
// [RULE7] button press/release and input changes raise events
// [RULE8] masks gate the pin only
// [RULE9] host masks continuous event, polls, then unmasks
// [RULE10] low battery: input valid above 4.3 V
// [RULE11] then valid until lockout plus 200 mV
// [RULE12] both inputs valid: draw from AC
// [RULE13] short battery: AC below 4.1 V selects USB
// [RULE14] dead battery: no switch back to USB
// [RULE15] good battery: detect 190 mV, lose 125 mV
// [RULE16] no input or blocked: battery feeds system
// [RULE17] bleed sink on when other input valid
// [RULE18] both sink fields 11b force sinks off
// [RULE19] software avoids sink field values 01b, 10b
// [RULE20] charger tests pin for short before charging
// [RULE21] phases: precharge, fast charge, constant voltage
// [RULE22] periodic 10 mA source checks battery presence
// [RULE23] comparator outputs synchronised before use
`ifndef PMES_DEFS_SVH
`define PMES_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PMES_REG_PATHCTL 8'h01
`define PMES_REG_INT 8'h02
`define PMES_PATHCTL_RST 8'h00
`define PMES_PC_AC_BLEED 7
`define PMES_PC_USB_BLEED 6
`define PMES_INT_FLAG_LO 0
`define PMES_INT_MASK_LO 4
`define PMES_EV_W 4
`define PMES_EV_PB 0
`define PMES_EV_AC 1
`define PMES_EV_USB 2
`define PMES_EV_FLT 3

// ----------------------------------------
// comparator vector positions
// ----------------------------------------
`define PMES_CMP_W 15
`define PMES_C_AC43 0
`define PMES_C_USB43 1
`define PMES_C_AC41 2
`define PMES_C_ACUV 3
`define PMES_C_USBUV 4
`define PMES_C_AC190 5
`define PMES_C_AC125 6
`define PMES_C_USB190 7
`define PMES_C_USB125 8
`define PMES_C_BAT15 9
`define PMES_C_BATUV 10
`define PMES_C_BATSC 11
`define PMES_C_BATLOWV 12
`define PMES_C_BATREG 13
`define PMES_C_FAULT 14

// ----------------------------------------
// timing
// ----------------------------------------
`define PMES_CLK_MHZ 125
`define PMES_HOLD_MS 1000
`define PMES_HOLD_CYC (`PMES_HOLD_MS * 1000 * `PMES_CLK_MHZ)
`define PMES_REARM_US 1
`define PMES_REARM_CYC (`PMES_REARM_US * `PMES_CLK_MHZ)
`define PMES_DET_PERIOD_US 1000
`define PMES_DET_PERIOD_CYC (`PMES_DET_PERIOD_US * `PMES_CLK_MHZ)
`define PMES_DET_ON_US 10
`define PMES_DET_ON_CYC (`PMES_DET_ON_US * `PMES_CLK_MHZ)

`endif

//--- inc/pmes_pkg.sv
// types shared by the supervisory logic
package pmes_pkg;
	typedef enum logic [1:0] {ST_ACTIVE, ST_HOLD, ST_POWERUP} pmes_state_t;
	typedef enum logic [1:0] {PATH_BAT, PATH_AC, PATH_USB} pmes_path_t;
	typedef enum logic [2:0] {CH_IDLE, CH_SHORT, CH_PRE, CH_FAST, CH_CV} pmes_chg_t;
endpackage

//--- rtl/pmes_supervisor.sv
// hard clear, event flags, power path selection and charger sequencing
`timescale 1ns/1ns
`default_nettype none
`include "pmes_defs.svh"

module pmes_supervisor import pmes_pkg::*; #(
	parameter int unsigned HOLD_CYC = `PMES_HOLD_CYC,
	parameter int unsigned DET_PERIOD_CYC = `PMES_DET_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// pins
	input wire logic hardClearPinN,
	input wire logic buttonInN,
	input wire logic chargerOn,
	output logic eventReqPinOut,
	output logic eventReqPinOe,
	// raw comparators
	input wire logic [`PMES_CMP_W-1:0] cmpRaw,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// power and charger controls
	output logic railsOn,
	output logic seqStart,
	output pmes_path_t pathSel,
	output logic acBleedOn,
	output logic usbBleedOn,
	output pmes_chg_t chgPhase,
	output logic shortTestSrc,
	output logic detSrc
);
	localparam int RearmBound = 200;

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [`PMES_CMP_W-1:0] cmpMeta_r;
	logic [`PMES_CMP_W-1:0] cmp_r;
	logic btnMeta_r, btn_r, btnPrev_r;

	// two flops per comparator bit, first flop read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < `PMES_CMP_W; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				cmpMeta_r[gi] <= srst ? 1'b0 : cmpRaw[gi]; // RULE23
				cmp_r[gi] <= srst ? 1'b0 : cmpMeta_r[gi]; // RULE23
			end
		end
	endgenerate

	// button is slow and debounced outside; same two-flop treatment
	always_ff @(posedge clk) begin
		btnMeta_r <= srst ? 1'b0 : ~buttonInN;
		btn_r <= srst ? 1'b0 : btnMeta_r;
		btnPrev_r <= srst ? 1'b0 : btn_r;
	end

	// ----------------------------------------
	// hard clear state machine
	// ----------------------------------------
	pmes_state_t state_r, state_nxt;
	logic [31:0] holdCnt_r;
	logic holdDone;
	logic regClr;
	logic railsOn_r, seqStart_r;

	assign holdDone = holdCnt_r >= HOLD_CYC;
	// registers held at default while the pin is low or in the hold window
	assign regClr = srst | ~hardClearPinN | (state_r == ST_HOLD); // RULE1

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_ACTIVE: if (!hardClearPinN) state_nxt = ST_HOLD; // RULE1
			ST_HOLD: if (hardClearPinN && holdDone) state_nxt = ST_POWERUP; // RULE2
			ST_POWERUP: state_nxt = hardClearPinN ? ST_ACTIVE : ST_HOLD; // RULE3
		endcase
	end

	// hold counter saturates so a long low never wraps
	always_ff @(posedge clk) begin
		if (srst || state_r != ST_HOLD)
			holdCnt_r <= 32'h0;
		else if (!holdDone)
			holdCnt_r <= holdCnt_r + 32'h1; // RULE2
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_ACTIVE;
			railsOn_r <= 1'b1;
			seqStart_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			railsOn_r <= (state_nxt == ST_ACTIVE); // RULE1
			seqStart_r <= (state_nxt == ST_POWERUP); // RULE3
		end
	end
	assign railsOn = railsOn_r;
	assign seqStart = seqStart_r;

	// ----------------------------------------
	// input qualification
	// ----------------------------------------
	logic lowBat, shortBat, deadBat;
	logic acDet, acLoss, usbDet, usbLoss;
	logic acValid_r, usbValid_r, acStick_r;

	assign shortBat = ~cmp_r[`PMES_C_BAT15];
	assign lowBat = ~cmp_r[`PMES_C_BATUV];
	assign deadBat = lowBat & ~shortBat;
	// low battery uses absolute levels, good battery the offset to the cell
	assign acDet = lowBat ? cmp_r[`PMES_C_AC43] : cmp_r[`PMES_C_AC190]; // RULE10 RULE15
	assign acLoss = lowBat ? ~cmp_r[`PMES_C_ACUV] : ~cmp_r[`PMES_C_AC125]; // RULE11 RULE15
	assign usbDet = lowBat ? cmp_r[`PMES_C_USB43] : cmp_r[`PMES_C_USB190]; // RULE10 RULE15
	assign usbLoss = lowBat ? ~cmp_r[`PMES_C_USBUV] : ~cmp_r[`PMES_C_USB125]; // RULE11 RULE15

	// hysteresis: set on detect, cleared on loss
	always_ff @(posedge clk) begin
		if (srst) begin
			acValid_r <= 1'b0;
			usbValid_r <= 1'b0;
		end else begin
			acValid_r <= acValid_r ? ~acLoss : acDet; // RULE10 RULE11
			usbValid_r <= usbValid_r ? ~usbLoss : usbDet; // RULE10 RULE11
		end
	end

	// ----------------------------------------
	// path selection and bleed sinks
	// ----------------------------------------
	logic acDrop, forceOff;
	pmes_path_t path_nxt, pathSel_r;
	logic [7:0] pathCtl_r;
	logic acBleed_r, usbBleed_r;

	// with a low cell AC under 4.1 V hands over to USB unless AC stuck
	assign acDrop = lowBat & usbValid_r & ~cmp_r[`PMES_C_AC41] & ~acStick_r; // RULE13 RULE14
	assign forceOff = pathCtl_r[`PMES_PC_AC_BLEED] & pathCtl_r[`PMES_PC_USB_BLEED]; // RULE18

	always_comb begin
		path_nxt = PATH_BAT; // RULE16
		if (state_r == ST_ACTIVE) begin
			if (acValid_r && !acDrop)
				path_nxt = PATH_AC; // RULE12
			else if (usbValid_r)
				path_nxt = PATH_USB; // RULE13
		end
	end

	// a dead cell keeps AC once chosen; the latch drops with the case
	always_ff @(posedge clk) begin
		if (srst || !deadBat || !acValid_r)
			acStick_r <= 1'b0;
		else if (pathSel_r == PATH_AC)
			acStick_r <= 1'b1; // RULE14
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pathSel_r <= PATH_BAT;
			acBleed_r <= 1'b0;
			usbBleed_r <= 1'b0;
		end else begin
			pathSel_r <= path_nxt;
			acBleed_r <= usbValid_r & ~acDet & ~forceOff; // RULE17 RULE18
			usbBleed_r <= acValid_r & ~usbDet & ~forceOff; // RULE17 RULE18
		end
	end
	assign pathSel = pathSel_r;
	assign acBleedOn = acBleed_r;
	assign usbBleedOn = usbBleed_r;

	// ----------------------------------------
	// event flags and request pin
	// ----------------------------------------
	logic [`PMES_EV_W-1:0] flags_r, flags_nxt, mask_r, evSet;
	logic acPrev_r, usbPrev_r;
	logic intRead, ppWrite, intWrite, intReq;
	logic [7:0] rearm_r;
	logic reqOe_r, reqOut_r;
	logic [7:0] rdata_r;

	assign intRead = regRd & (regAddr == `PMES_REG_INT);
	assign ppWrite = regWr & (regAddr == `PMES_REG_PATHCTL);
	assign intWrite = regWr & (regAddr == `PMES_REG_INT);

	// edge events set at once; a standing fault skips the read cycle and the refire gap
	assign evSet[`PMES_EV_PB] = btn_r ^ btnPrev_r; // RULE7
	assign evSet[`PMES_EV_AC] = acValid_r ^ acPrev_r; // RULE7
	assign evSet[`PMES_EV_USB] = usbValid_r ^ usbPrev_r; // RULE7
	assign evSet[`PMES_EV_FLT] = cmp_r[`PMES_C_FAULT] & (rearm_r == 8'h0) & ~intRead; // RULE5 RULE6
	// edge events win over the read clear
	assign flags_nxt = (intRead ? '0 : flags_r) | evSet; // RULE4 RULE5
	assign intReq = |(flags_r & ~mask_r); // RULE8

	always_ff @(posedge clk) begin
		acPrev_r <= srst ? 1'b0 : acValid_r;
		usbPrev_r <= srst ? 1'b0 : usbValid_r;
	end

	// refire gap only after reading a standing fault; a fresh fault flags at once
	always_ff @(posedge clk) begin
		if (regClr)
			rearm_r <= 8'h0;
		else if (intRead && cmp_r[`PMES_C_FAULT])
			rearm_r <= 8'(`PMES_REARM_CYC); // RULE6
		else if (rearm_r != 8'h0)
			rearm_r <= rearm_r - 8'h1;
	end

	always_ff @(posedge clk) begin
		if (regClr) begin
			flags_r <= '0; // RULE1
			mask_r <= '0;
			pathCtl_r <= `PMES_PATHCTL_RST;
			reqOe_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			if (intWrite)
				mask_r <= regWdata[`PMES_INT_MASK_LO +: `PMES_EV_W];
			if (ppWrite)
				pathCtl_r <= regWdata;
			reqOe_r <= intReq; // RULE4 RULE5 RULE8
		end
	end

	// open-drain: level is always low, only the enable moves
	always_ff @(posedge clk) begin
		reqOut_r <= 1'b0;
	end
	assign eventReqPinOut = reqOut_r;
	assign eventReqPinOe = reqOe_r;

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (srst)
			rdata_r <= 8'h0;
		else if (regRd)
			rdata_r <= (regAddr == `PMES_REG_PATHCTL) ? pathCtl_r :
				(regAddr == `PMES_REG_INT) ? {mask_r, flags_r} : 8'h0;
	end
	assign regRdata = rdata_r;

	// ----------------------------------------
	// charger sequencing
	// ----------------------------------------
	pmes_chg_t chg_r, chg_nxt;
	logic chgEn;
	logic [31:0] detCnt_r;
	logic detSrc_r, shortSrc_r;

	assign chgEn = chargerOn & (state_r == ST_ACTIVE) & (pathSel_r != PATH_BAT);

	always_comb begin
		chg_nxt = chg_r;
		unique case (chg_r)
			CH_IDLE: if (chgEn) chg_nxt = CH_SHORT; // RULE20
			CH_SHORT: if (cmp_r[`PMES_C_BATSC]) chg_nxt = CH_PRE; // RULE20
			CH_PRE: if (cmp_r[`PMES_C_BATLOWV]) chg_nxt = CH_FAST; // RULE21
			CH_FAST: if (cmp_r[`PMES_C_BATREG]) chg_nxt = CH_CV; // RULE21
			CH_CV: chg_nxt = CH_CV;
			default: chg_nxt = CH_IDLE;
		endcase
		if (!chgEn)
			chg_nxt = CH_IDLE;
	end

	// presence check: short source pulse once per period while enabled
	always_ff @(posedge clk) begin
		if (srst || !chgEn)
			detCnt_r <= 32'h0;
		else if (detCnt_r >= DET_PERIOD_CYC - 1)
			detCnt_r <= 32'h0;
		else
			detCnt_r <= detCnt_r + 32'h1; // RULE22
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			chg_r <= CH_IDLE;
			shortSrc_r <= 1'b0;
			detSrc_r <= 1'b0;
		end else begin
			chg_r <= chg_nxt;
			shortSrc_r <= (chg_nxt == CH_SHORT); // RULE20
			detSrc_r <= chgEn & (detCnt_r < `PMES_DET_ON_CYC); // RULE22
		end
	end
	assign chgPhase = chg_r;
	assign shortTestSrc = shortSrc_r;
	assign detSrc = detSrc_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [31:0] offCnt_r;
	always_ff @(posedge clk) begin
		if (srst || railsOn_r)
			offCnt_r <= 32'h0;
		else if (offCnt_r != 32'hffffffff)
			offCnt_r <= offCnt_r + 32'h1;
	end

	property p_clear_off;
		@(posedge clk) disable iff (srst) !hardClearPinN |=> !railsOn_r;
	endproperty
	a_clear_off: assert property (p_clear_off) else $error("rails on under hard clear"); // RULE1
	property p_min_off;
		@(posedge clk) disable iff (srst) $rose(railsOn_r) && $past(offCnt_r) != 32'h0
			|-> $past(offCnt_r) >= HOLD_CYC;
	endproperty
	a_min_off: assert property (p_min_off) else $error("rails back too early"); // RULE2
	property p_seq;
		@(posedge clk) disable iff (srst) $rose(railsOn_r) |-> $past(seqStart_r);
	endproperty
	a_seq: assert property (p_seq) else $error("no power-up sequence start"); // RULE3
	property p_req_low;
		@(posedge clk) disable iff (regClr) intReq |=> reqOe_r;
	endproperty
	a_req_low: assert property (p_req_low) else $error("request pin not pulled"); // RULE4
	property p_read_clr;
		@(posedge clk) disable iff (regClr) intRead && evSet == '0 |=> flags_r == '0 ##1 !reqOe_r;
	endproperty
	a_read_clr: assert property (p_read_clr) else $error("read did not clear"); // RULE5
	property p_persist;
		@(posedge clk) disable iff (regClr)
			intRead && !mask_r[`PMES_EV_FLT] && cmp_r[`PMES_C_FAULT] [*1] ##1
			(cmp_r[`PMES_C_FAULT] && !intRead && !mask_r[`PMES_EV_FLT]) [*8]
			|-> ##[1:RearmBound] reqOe_r;
	endproperty
	a_persist: assert property (p_persist) else $error("fault not re-asserted"); // RULE6
	property p_button;
		@(posedge clk) disable iff (regClr) $changed(btn_r) |=> flags_r[`PMES_EV_PB];
	endproperty
	a_button: assert property (p_button) else $error("button event lost"); // RULE7
	property p_mask;
		@(posedge clk) disable iff (regClr) (flags_r & ~mask_r) == '0 |=> !reqOe_r;
	endproperty
	a_mask: assert property (p_mask) else $error("masked event drove pin"); // RULE8
	property p_ac_prio;
		@(posedge clk) disable iff (srst)
			state_r == ST_ACTIVE && acValid_r && usbValid_r && cmp_r[`PMES_C_AC41]
			|=> pathSel_r == PATH_AC;
	endproperty
	a_ac_prio: assert property (p_ac_prio) else $error("AC not preferred"); // RULE12
	property p_bat;
		@(posedge clk) disable iff (srst) !acValid_r && !usbValid_r |=> pathSel_r == PATH_BAT;
	endproperty
	a_bat: assert property (p_bat) else $error("battery not selected"); // RULE16
	property p_force;
		@(posedge clk) disable iff (regClr) forceOff |=> !acBleed_r && !usbBleed_r;
	endproperty
	a_force: assert property (p_force) else $error("sink on while forced off"); // RULE18
	property p_short_first;
		@(posedge clk) disable iff (srst) chg_r == CH_IDLE ##1 chg_r != CH_IDLE
			|-> chg_r == CH_SHORT;
	endproperty
	a_short_first: assert property (p_short_first) else $error("charge without short test"); // RULE20
endmodule
`default_nettype wire
